// ### metering_cfg_pkg.sv
`default_nettype none
package metering_cfg_pkg;

  // Register port geometry.
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;

  // Register addresses.
  localparam logic [15:0] COMP_MODE_ADDR   = 16'he60e;
  localparam logic [15:0] NOM_LO_ADDR      = 16'he620;
  localparam logic [15:0] NOM_HI_ADDR      = 16'he622;
  localparam logic [15:0] ACTIVE_MODE_ADDR = 16'he624;

  // Field positions inside computation_mode.
  localparam int unsigned PULSE1_LSB = 0;
  localparam int unsigned PULSE2_LSB = 3;
  localparam int unsigned PULSE3_LSB = 6;
  localparam int unsigned ANGLE_LSB  = 9;
  localparam int unsigned NOM_A_BIT  = 12;
  localparam int unsigned NOM_B_BIT  = 13;
  localparam int unsigned NOM_C_BIT  = 14;
  localparam int unsigned PENDING_BIT = 15;

  // Values after reset and writable bits.
  localparam logic [15:0] COMP_MODE_RESET = 16'h01ff;
  localparam logic [15:0] COMP_MODE_MASK  = 16'h77ff;
  localparam logic [15:0] NOM_WORD_RESET  = 16'h0000;

  typedef enum logic [1:0] {
    ANGLE_V_TO_I = 2'h0,
    ANGLE_V_TO_V = 2'h1,
    ANGLE_I_TO_I = 2'h2,
    ANGLE_NONE   = 2'h3
  } angle_mode_t;

  typedef struct packed {
    logic [2:0]  nom_use;
    angle_mode_t angle;
    logic [2:0]  pulse3_sel;
    logic [2:0]  pulse2_sel;
    logic [2:0]  pulse1_sel;
  } comp_cfg_t;

  typedef struct packed {
    logic v_to_i;
    logic v_to_v;
    logic i_to_i;
    logic none;
  } angle_enables_t;

endpackage : metering_cfg_pkg
`default_nettype wire

// ### metering_computation_mode_config.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RL1 - Each first-pulse phase-select bit, reset to one, includes its phase in the first pulse sum.
// RL2 - The second-pulse phase-select bits each add their phase; all three set give the full sum.
// RL3 - The third-pulse phase-select bits each add their phase; all three set give the full sum.
// RL4 - Bits 10:9, reset 00, select V-to-I, V-to-V, I-to-I or no angle measurement.
// RL5 - Phase A apparent power uses the nominal voltage when its enable is set; it resets to 0.
// RL6 - With the phase A enable set, the phase A input is ignored for every rms voltage use.
// RL7 - With the phase B enable set, phase B rms voltage and apparent power use the nominal value.
// RL8 - Phase C uses measured voltage while its enable is 0 and the nominal value when set.
// RL9 - The 16-bit mode register is read/write, reserved bits read zero, and applies to later work.
module metering_computation_mode_config
  import metering_cfg_pkg::*;
#(
  parameter int unsigned VW = 24,
  parameter int unsigned IW = 24,
  parameter int unsigned PW = 24
)
(
  // Clock and reset.
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  // Register port.
  input  wire logic [ADDR_W-1:0]    addr_i,
  input  wire logic [DATA_W-1:0]    wdata_i,
  input  wire logic                 we_i,
  input  wire logic                 re_i,
  output logic [DATA_W-1:0]         rdata_o,
  // Computation cycle boundary.
  input  wire logic                 compute_tick_i,
  // Per-phase measurements.
  input  wire logic [VW-1:0]        vrms_a_i,
  input  wire logic [VW-1:0]        vrms_b_i,
  input  wire logic [VW-1:0]        vrms_c_i,
  input  wire logic [IW-1:0]        irms_a_i,
  input  wire logic [IW-1:0]        irms_b_i,
  input  wire logic [IW-1:0]        irms_c_i,
  input  wire logic signed [PW-1:0] power_a_i,
  input  wire logic signed [PW-1:0] power_b_i,
  input  wire logic signed [PW-1:0] power_c_i,
  // Voltage and apparent power results.
  output logic [VW-1:0]             eff_vrms_a_o,
  output logic [VW-1:0]             eff_vrms_b_o,
  output logic [VW-1:0]             eff_vrms_c_o,
  output logic [VW+IW-1:0]          apparent_a_o,
  output logic [VW+IW-1:0]          apparent_b_o,
  output logic [VW+IW-1:0]          apparent_c_o,
  // Pulse output sources.
  output logic signed [PW+1:0]      pulse_output_first_o,
  output logic signed [PW+1:0]      pulse_output_second_o,
  output logic signed [PW+1:0]      pulse_output_third_o,
  output logic [2:0]                pulse_all_phases_o,
  // Angle measurement and state.
  output angle_enables_t            angle_enables_o,
  output logic                      config_pending_o
);

  // The nominal value is held in two 16-bit words, so VW cannot exceed 32.
  if (VW < 1 || VW > 32)
  begin : g_vw_check
    $error("VW must lie in 1..32");
  end
  if (IW < 1)
  begin : g_iw_check
    $error("IW must be positive");
  end
  if (PW < 2)
  begin : g_pw_check
    $error("PW must be at least 2");
  end

  // Address decode.
  wire logic hit_mode   = (addr_i == COMP_MODE_ADDR);
  wire logic hit_nom_lo = (addr_i == NOM_LO_ADDR);
  wire logic hit_nom_hi = (addr_i == NOM_HI_ADDR);
  wire logic hit_active = (addr_i == ACTIVE_MODE_ADDR);
  // The active view is read-only; a write to it is dropped without effect.

  wire logic wr_mode   = we_i && hit_mode;
  wire logic wr_nom_lo = we_i && hit_nom_lo;
  wire logic wr_nom_hi = we_i && hit_nom_hi;

  // Software-visible registers.
  logic [15:0] comp_mode_q;
  logic [15:0] nom_lo_q;
  logic [15:0] nom_hi_q;
  logic [15:0] active_mode_q;
  logic        pending_q;
  logic [DATA_W-1:0] rdata_q;

  // Reserved bits never store a one, so they always read back as zero.
  wire logic [15:0] comp_mode_d = wdata_i & COMP_MODE_MASK; // RL9

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      comp_mode_q <= COMP_MODE_RESET; // RL1 RL4 RL5
    end
    else if (wr_mode)
    begin
      comp_mode_q <= comp_mode_d; // RL9
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      nom_lo_q <= NOM_WORD_RESET;
      nom_hi_q <= NOM_WORD_RESET;
    end
    else
    begin
      if (wr_nom_lo)
      begin
        nom_lo_q <= wdata_i;
      end
      if (wr_nom_hi)
      begin
        nom_hi_q <= wdata_i;
      end
    end
  end

  // The datapath only sees a new mode at a computation boundary, so a
  // half-finished computation never mixes old and new phase selections.
  wire logic load_active = compute_tick_i && (pending_q || wr_mode);
  wire logic [15:0] active_src = wr_mode ? comp_mode_d : comp_mode_q;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      active_mode_q <= COMP_MODE_RESET;
    end
    else if (load_active)
    begin
      active_mode_q <= active_src; // RL9
    end
  end

  // A write in the same cycle as a tick is applied at once, so it is not pending.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pending_q <= 1'b0;
    end
    else if (compute_tick_i)
    begin
      pending_q <= 1'b0;
    end
    else if (wr_mode)
    begin
      pending_q <= 1'b1;
    end
  end

  // Read data stand in the cycle after the strobe and only there.
  // The active view lets software see whether a written mode has reached the datapath.
  wire logic [15:0] active_view = {pending_q, active_mode_q[14:0]};
  wire logic [15:0] rd_mux =
    hit_mode   ? comp_mode_q :
    hit_nom_lo ? nom_lo_q    :
    hit_nom_hi ? nom_hi_q    :
    hit_active ? active_view :
    16'h0000;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata_q <= '0;
    end
    else if (re_i)
    begin
      rdata_q <= rd_mux;
    end
    else
    begin
      rdata_q <= '0;
    end
  end

  assign rdata_o = rdata_q;

  // Field taps of the settings in force; reserved bit 11 is never read.
  wire logic [2:0] pulse1_phase_select         = active_mode_q[PULSE1_LSB +: 3]; // RL1
  wire logic [2:0] pulse2_phase_select         = active_mode_q[PULSE2_LSB +: 3]; // RL2
  wire logic [2:0] pulse3_phase_select         = active_mode_q[PULSE3_LSB +: 3]; // RL3
  wire logic [1:0] angle_measure_select        = active_mode_q[ANGLE_LSB +: 2];  // RL4
  wire logic       phase_a_nominal_voltage_use = active_mode_q[NOM_A_BIT];       // RL5 RL6
  wire logic       phase_b_nominal_voltage_use = active_mode_q[NOM_B_BIT];       // RL7
  wire logic       phase_c_nominal_voltage_use = active_mode_q[NOM_C_BIT];       // RL8

  comp_cfg_t cfg;
  assign cfg = '{
    nom_use:    {phase_c_nominal_voltage_use, phase_b_nominal_voltage_use,
                 phase_a_nominal_voltage_use},
    angle:      angle_mode_t'(angle_measure_select),
    pulse3_sel: pulse3_phase_select,
    pulse2_sel: pulse2_phase_select,
    pulse1_sel: pulse1_phase_select
  };

  // Only the low VW bits of the two nominal words reach the datapath; higher bits
  // are kept for software but have no effect on any computation.
  wire logic [31:0] nom_word     = {nom_hi_q, nom_lo_q};
  wire logic [VW-1:0] nominal_v  = nom_word[VW-1:0];

  // Angle measurement selection.
  assign angle_enables_o.v_to_i = (cfg.angle == ANGLE_V_TO_I); // RL4
  assign angle_enables_o.v_to_v = (cfg.angle == ANGLE_V_TO_V); // RL4
  assign angle_enables_o.i_to_i = (cfg.angle == ANGLE_I_TO_I); // RL4
  assign angle_enables_o.none   = (cfg.angle == ANGLE_NONE);   // RL4

  // Software can poll this flag to learn when a written mode is in force.
  assign config_pending_o = pending_q;

  // Voltage substitution per phase.
  // One stored nominal value serves all three phases.
  voltage_select #(.VW(VW), .IW(IW)) u_volt_a
  (
    .clk_i          (clk_i),
    .resetn_i       (resetn_i),
    .nominal_use_i  (cfg.nom_use[0]), // RL5 RL6
    .sample_valid_i (compute_tick_i),
    .measured_v_i   (vrms_a_i),
    .nominal_v_i    (nominal_v),
    .irms_i         (irms_a_i),
    .eff_v_o        (eff_vrms_a_o),
    .apparent_o     (apparent_a_o)
  );

  voltage_select #(.VW(VW), .IW(IW)) u_volt_b
  (
    .clk_i          (clk_i),
    .resetn_i       (resetn_i),
    .nominal_use_i  (cfg.nom_use[1]), // RL7
    .sample_valid_i (compute_tick_i),
    .measured_v_i   (vrms_b_i),
    .nominal_v_i    (nominal_v),
    .irms_i         (irms_b_i),
    .eff_v_o        (eff_vrms_b_o),
    .apparent_o     (apparent_b_o)
  );

  voltage_select #(.VW(VW), .IW(IW)) u_volt_c
  (
    .clk_i          (clk_i),
    .resetn_i       (resetn_i),
    .nominal_use_i  (cfg.nom_use[2]), // RL8
    .sample_valid_i (compute_tick_i),
    .measured_v_i   (vrms_c_i),
    .nominal_v_i    (nominal_v),
    .irms_i         (irms_c_i),
    .eff_v_o        (eff_vrms_c_o),
    .apparent_o     (apparent_c_o)
  );

  // Pulse output sources.
  // All three sums take the same samples, so they always describe one computation.
  phase_sum #(.PW(PW)) u_pulse1
  (
    .clk_i          (clk_i),
    .resetn_i       (resetn_i),
    .phase_sel_i    (cfg.pulse1_sel), // RL1
    .sample_valid_i (compute_tick_i),
    .power_a_i      (power_a_i),
    .power_b_i      (power_b_i),
    .power_c_i      (power_c_i),
    .sum_o          (pulse_output_first_o),
    .all_phases_o   (pulse_all_phases_o[0])
  );

  phase_sum #(.PW(PW)) u_pulse2
  (
    .clk_i          (clk_i),
    .resetn_i       (resetn_i),
    .phase_sel_i    (cfg.pulse2_sel), // RL2
    .sample_valid_i (compute_tick_i),
    .power_a_i      (power_a_i),
    .power_b_i      (power_b_i),
    .power_c_i      (power_c_i),
    .sum_o          (pulse_output_second_o),
    .all_phases_o   (pulse_all_phases_o[1])
  );

  phase_sum #(.PW(PW)) u_pulse3
  (
    .clk_i          (clk_i),
    .resetn_i       (resetn_i),
    .phase_sel_i    (cfg.pulse3_sel), // RL3
    .sample_valid_i (compute_tick_i),
    .power_a_i      (power_a_i),
    .power_b_i      (power_b_i),
    .power_c_i      (power_c_i),
    .sum_o          (pulse_output_third_o),
    .all_phases_o   (pulse_all_phases_o[2])
  );

endmodule : metering_computation_mode_config
`default_nettype wire

// ### mode_cfg_sva.sv
`timescale 1ns/1ps
`default_nettype none
module mode_cfg_sva
  import metering_cfg_pkg::*;
#(
  parameter int unsigned VW = 24,
  parameter int unsigned IW = 24,
  parameter int unsigned PW = 24
)
(
  // Clock, reset and register port.
  input wire logic                 clk_i,
  input wire logic                 resetn_i,
  input wire logic [ADDR_W-1:0]    addr_i,
  input wire logic                 we_i,
  input wire logic                 re_i,
  input wire logic [DATA_W-1:0]    rdata_o,
  // Computation results.
  input wire logic                 compute_tick_i,
  input wire logic [VW+IW-1:0]     apparent_a_o,
  input wire logic signed [PW+1:0] pulse_output_first_o,
  input wire logic [2:0]           pulse_all_phases_o,
  input wire angle_enables_t       angle_enables_o,
  input wire logic                 config_pending_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire mapped = addr_i inside {COMP_MODE_ADDR, NOM_LO_ADDR, NOM_HI_ADDR, ACTIVE_MODE_ADDR};
  sequence s_mode_write;
    we_i && addr_i == COMP_MODE_ADDR;
  endsequence
  sequence s_quiet;
    !compute_tick_i;
  endsequence
  a_read_one_cycle: assert property (!re_i |=> rdata_o == '0)
    else $error("read data outside its cycle");
  a_reserved_read_zero: assert property (re_i && addr_i == COMP_MODE_ADDR |=>
    !rdata_o[11] && !rdata_o[15]) else $error("reserved mode bit read set");
  a_unmapped_read_zero: assert property (re_i && !mapped |=> rdata_o == '0)
    else $error("unmapped read not zero");
  a_pending_after_write: assert property (s_mode_write ##0 s_quiet |=> config_pending_o)
    else $error("pending not raised");
  a_pending_cleared: assert property (compute_tick_i |=> !config_pending_o)
    else $error("pending not cleared by tick");
  a_pending_held: assert property (config_pending_o && !compute_tick_i |=> config_pending_o)
    else $error("pending lost without tick");
  a_angle_one_hot: assert property ($onehot(angle_enables_o))
    else $error("angle enables not one hot");
  a_angle_on_tick: assert property (s_quiet |=> $stable(angle_enables_o))
    else $error("angle mode changed without tick");
  a_sums_held: assert property (s_quiet |=> $stable(pulse_output_first_o)
    && $stable(pulse_all_phases_o)) else $error("pulse sum changed without tick");
  a_apparent_held: assert property (s_quiet |=> $stable(apparent_a_o))
    else $error("apparent power changed without tick");
endmodule : mode_cfg_sva
bind metering_computation_mode_config mode_cfg_sva #(.VW(VW), .IW(IW), .PW(PW)) sva
(
  .clk_i                (clk_i),
  .resetn_i             (resetn_i),
  .addr_i               (addr_i),
  .we_i                 (we_i),
  .re_i                 (re_i),
  .rdata_o              (rdata_o),
  .compute_tick_i       (compute_tick_i),
  .apparent_a_o         (apparent_a_o),
  .pulse_output_first_o (pulse_output_first_o),
  .pulse_all_phases_o   (pulse_all_phases_o),
  .angle_enables_o      (angle_enables_o),
  .config_pending_o     (config_pending_o)
);
`default_nettype wire

// ### phase_sum.sv
`timescale 1ns/1ps
`default_nettype none
module phase_sum
#(
  parameter int unsigned PW = 24
)
(
  // Clock and reset.
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  // Selection and samples.
  input  wire logic [2:0]           phase_sel_i,
  input  wire logic                 sample_valid_i,
  input  wire logic signed [PW-1:0] power_a_i,
  input  wire logic signed [PW-1:0] power_b_i,
  input  wire logic signed [PW-1:0] power_c_i,
  // Result.
  output logic signed [PW+1:0]      sum_o,
  output logic                      all_phases_o
);

  if (PW < 2)
  begin : g_pw_check
    $error("phase_sum: PW must be at least 2");
  end

  // A phase whose select bit is clear contributes zero to the sum.
  // Two guard bits keep the sum of three full-scale phases from wrapping.
  wire logic signed [PW+1:0] term_a = phase_sel_i[0] ? (PW+2)'(power_a_i) : '0;
  wire logic signed [PW+1:0] term_b = phase_sel_i[1] ? (PW+2)'(power_b_i) : '0;
  wire logic signed [PW+1:0] term_c = phase_sel_i[2] ? (PW+2)'(power_c_i) : '0;
  wire logic signed [PW+1:0] sum_d  = term_a + term_b + term_c;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sum_o        <= '0;
      all_phases_o <= 1'b0;
    end
    else if (sample_valid_i)
    begin
      sum_o        <= sum_d;
      all_phases_o <= &phase_sel_i;
    end
  end

endmodule : phase_sum
`default_nettype wire

// ### test_metering_computation_mode_config.sv
`timescale 1ns/1ps
`default_nettype none
module test_metering_computation_mode_config;
  import metering_cfg_pkg::*;
  logic clk_i = 0, resetn_i = 0, we_i = 0, re_i = 0, compute_tick_i = 0;
  logic [15:0]        addr_i = '0, wdata_i = '0, rdata_o;
  logic [23:0]        va = 24'h000100, vb = 24'h000200, vc = 24'h000300;
  logic [23:0]        ia = 24'h000002, ib = 24'h000003, ic = 24'h000005;
  logic signed [23:0] pa = 24'sd1000, pb = 24'sd200, pc = -24'sd30;
  logic [23:0]        ea, eb, ec;
  logic [47:0]        sa, sb, sc;
  logic signed [25:0] p1, p2, p3;
  logic [2:0]         allp;
  angle_enables_t     ang;
  logic               pend;
  int                 failures = 0, comparisons = 0;
  always #5 clk_i = ~clk_i;
  metering_computation_mode_config dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
    .compute_tick_i(compute_tick_i), .vrms_a_i(va), .vrms_b_i(vb), .vrms_c_i(vc),
    .irms_a_i(ia), .irms_b_i(ib), .irms_c_i(ic), .power_a_i(pa), .power_b_i(pb),
    .power_c_i(pc), .eff_vrms_a_o(ea), .eff_vrms_b_o(eb), .eff_vrms_c_o(ec),
    .apparent_a_o(sa), .apparent_b_o(sb), .apparent_c_o(sc), .pulse_output_first_o(p1),
    .pulse_output_second_o(p2), .pulse_output_third_o(p3), .pulse_all_phases_o(allp),
    .angle_enables_o(ang), .config_pending_o(pend));
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  task automatic tick;
    @(posedge clk_i);
    compute_tick_i <= 1'b1;
    @(posedge clk_i);
    compute_tick_i <= 1'b0;
    #1;
  endtask : tick
  // Signed sum of the selected phase powers, sign extended to the output width.
  function automatic logic signed [25:0] psum(input logic [2:0] s);
    psum = '0;
    if (s[0]) psum += pa;
    if (s[1]) psum += pb;
    if (s[2]) psum += pc;
  endfunction : psum
  task automatic test_reset;
    logic [15:0] d;
    rd(COMP_MODE_ADDR, d);
    check("mode reset", d, 16'h01ff);
    check("angle reset", ang, 4'b1000);
    check("pending reset", pend, 1'b0);
    $display("test reset done");
  endtask : test_reset
  task automatic test_pulse;
    logic [2:0] s1, s2, s3;
    for (int k = 0; k < 8; k++)
    begin
      s1 = 3'(k);
      s2 = 3'h7 - s1;
      s3 = s1 ^ 3'h5;
      wr(COMP_MODE_ADDR, {7'h0, s3, s2, s1});
      #1 check("pending set", pend, 1'b1);
      tick();
      check("pending clear", pend, 1'b0);
      tick();
      check("pulse1", p1, psum(s1));
      check("pulse2", p2, psum(s2));
      check("pulse3", p3, psum(s3));
      check("all phases", allp, {s3 == 3'h7, s2 == 3'h7, s1 == 3'h7});
    end
    $display("test pulse done");
  endtask : test_pulse
  task automatic test_angle;
    for (int k = 0; k < 4; k++)
    begin
      wr(COMP_MODE_ADDR, {5'h0, 2'(k), 9'h1ff});
      tick();
      check("angle", ang, 4'b1000 >> k);
    end
    $display("test angle done");
  endtask : test_angle
  task automatic test_nominal;
    logic [23:0] xa, xb, xc;
    wr(NOM_LO_ADDR, 16'h1234);
    wr(NOM_HI_ADDR, 16'h0056);
    for (int n = 0; n < 8; n++)
    begin
      wr(COMP_MODE_ADDR, 16'h01ff | 16'(n << 12));
      tick();
      tick();
      xa = n[0] ? 24'h561234 : va;
      xb = n[1] ? 24'h561234 : vb;
      xc = n[2] ? 24'h561234 : vc;
      check("vrms a", ea, xa);
      check("vrms b", eb, xb);
      check("vrms c", ec, xc);
      check("apparent a", sa, 48'(xa) * 48'(ia));
      check("apparent b", sb, 48'(xb) * 48'(ib));
      check("apparent c", sc, 48'(xc) * 48'(ic));
    end
    $display("test nominal done");
  endtask : test_nominal
  task automatic test_regs;
    logic [15:0] d;
    wr(COMP_MODE_ADDR, 16'hffff);
    wr(ACTIVE_MODE_ADDR, 16'h0000);
    rd(COMP_MODE_ADDR, d);
    check("mode mask", d, 16'h77ff);
    rd(ACTIVE_MODE_ADDR, d);
    check("active view", d, 16'hf1ff);
    rd(NOM_LO_ADDR, d);
    check("nominal low", d, 16'h1234);
    rd(NOM_HI_ADDR, d);
    check("nominal high", d, 16'h0056);
    wr(16'h1000, 16'hffff);
    rd(16'h1000, d);
    check("unmapped", d, 16'h0000);
    $display("test regs done");
  endtask : test_regs
  // A mode write in the same cycle as a tick goes straight into force.
  task automatic test_same_cycle;
    @(posedge clk_i);
    addr_i         <= COMP_MODE_ADDR;
    wdata_i        <= 16'h05ff;
    we_i           <= 1'b1;
    compute_tick_i <= 1'b1;
    @(posedge clk_i);
    we_i           <= 1'b0;
    compute_tick_i <= 1'b0;
    #1 check("same cycle pending", pend, 1'b0);
    check("same cycle angle", ang, 4'b0010);
    $display("test same cycle done");
  endtask : test_same_cycle
  task automatic tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    test_reset();
    test_pulse();
    test_angle();
    test_nominal();
    test_regs();
    test_same_cycle();
    tally_and_finish();
  end
  initial
  begin
    #100000;
    failures++;
    tally_and_finish();
  end
endmodule : test_metering_computation_mode_config
`default_nettype wire

// ### voltage_select.sv
`timescale 1ns/1ps
`default_nettype none
module voltage_select
#(
  parameter int unsigned VW = 24,
  parameter int unsigned IW = 24
)
(
  // Clock and reset.
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  // Control and samples.
  input  wire logic          nominal_use_i,
  input  wire logic          sample_valid_i,
  input  wire logic [VW-1:0] measured_v_i,
  input  wire logic [VW-1:0] nominal_v_i,
  input  wire logic [IW-1:0] irms_i,
  // Results.
  output logic [VW-1:0]      eff_v_o,
  output logic [VW+IW-1:0]   apparent_o
);

  if (VW < 1 || IW < 1)
  begin : g_width_check
    $error("voltage_select: widths must be positive");
  end

  // With substitution on, the measured voltage is ignored entirely.
  wire logic [VW-1:0]    eff_v_d    = nominal_use_i ? nominal_v_i : measured_v_i;
  wire logic [VW+IW-1:0] apparent_d = (VW+IW)'(eff_v_d) * (VW+IW)'(irms_i);

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      eff_v_o    <= '0;
      apparent_o <= '0;
    end
    else if (sample_valid_i)
    begin
      eff_v_o    <= eff_v_d;
      apparent_o <= apparent_d;
    end
  end

endmodule : voltage_select
`default_nettype wire
